// ==== mcd_core_decode.sv ====
// Core instruction decode and execute engine with an Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "mcd_params.svh"

module mcd_core_decode
  import mcd_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int FILE_WORDS = 128
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Side effects
  output logic wdt_clear,
  output logic t0_prescaler_clear,
  output logic standby
);

  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b);
    add9 = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic half_carry(input logic [7:0] a, input logic [7:0] b);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    half_carry = s[4];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] file_q [FILE_WORDS];
  logic [12:0] stack_q [STACK_DEPTH];
  mcd_state_t state_q, state_d;
  logic [13:0] instr_q, instr_d;
  logic [7:0] wreg_q, wreg_d;
  logic [7:0] status_q, status_d;
  logic [12:0] pc_q, pc_d;
  logic [7:0] pchl_q, pchl_d;
  logic [7:0] pins_q, pins_d;
  logic [2:0] sp_q, sp_d;
  logic [1:0] events_q, events_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [6:0] faddr_q, faddr_d;
  logic wdt_q, wdt_d, t0c_q, t0c_d, stby_q, stby_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  mcd_file_t fw;
  logic push, pop;
  logic [12:0] push_val;
  logic bus_wr;

  // ----------------------------------------------------------------
  // Decode fields
  // ----------------------------------------------------------------
  logic [1:0] cls;
  logic [3:0] op;
  logic dst;
  logic [6:0] fa;
  logic [2:0] bn;
  logic [7:0] lit, fval, src;

  always_comb
  begin
    cls = instr_q[13:12];
    op = instr_q[11:8];
    dst = instr_q[7];
    fa = instr_q[6:0];
    bn = instr_q[9:7];
    lit = instr_q[7:0];
    fval = file_q[fa];
    // Port address is read from pins so external drive wins over the latch.
    src = (fa == `MCD_PORT_ADDR) ? pins_q : fval;
  end

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] res;
    logic [8:0] sum;
    logic wr_res, skip, jmp;
    res = 8'h00;
    sum = 9'h000;
    wr_res = 1'b0;
    skip = 1'b0;
    jmp = 1'b0;
    state_d = state_q;
    instr_d = instr_q;
    wreg_d = wreg_q;
    status_d = status_q;
    pc_d = pc_q;
    sp_d = sp_q;
    events_d = events_q;
    fw = '{addr: fa, data: 8'h00, wr: 1'b0};
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_q + 13'h0001;
    wdt_d = 1'b0;
    t0c_d = 1'b0;
    stby_d = stby_q;
    case (state_q)
      MCD_IDLE: ;
      MCD_READ: state_d = MCD_EXEC;
      MCD_EXEC:
      begin
        state_d = MCD_IDLE;
        pc_d = pc_q + 13'h0001;
        case (cls)
          2'b00:
          begin
            case (op)
              4'b0111:
              begin
                sum = add9(src, wreg_q);
                res = sum[7:0];
                status_d[`MCD_ST_C] = sum[8];
                status_d[`MCD_ST_DIGIT_CARRY] = half_carry(src, wreg_q);
                status_d[`MCD_ST_Z] = (res == 8'h00);
                wr_res = 1'b1;
              end
              4'b0010:
              begin
                sum = add9(src, ~wreg_q) + 9'h001;
                res = sum[7:0];
                status_d[`MCD_ST_C] = sum[8];
                status_d[`MCD_ST_DIGIT_CARRY] = ({1'b0, src[3:0]} + {1'b0, ~wreg_q[3:0]} + 5'h01) > 5'h0f;
                status_d[`MCD_ST_Z] = (res == 8'h00);
                wr_res = 1'b1;
              end
              4'b0101, 4'b0100, 4'b0110, 4'b1000, 4'b1001, 4'b0011, 4'b1010:
              begin
                case (op)
                  4'b0101: res = src & wreg_q;
                  4'b0100: res = src | wreg_q;
                  4'b0110: res = src ^ wreg_q;
                  4'b1000: res = src;
                  4'b1001: res = ~src;
                  4'b0011: res = src - 8'h01;
                  default: res = src + 8'h01;
                endcase
                status_d[`MCD_ST_Z] = (res == 8'h00);
                wr_res = 1'b1;
              end
              4'b1011, 4'b1111:
              begin
                res = (op == 4'b1011) ? src - 8'h01 : src + 8'h01;
                skip = (res == 8'h00);
                wr_res = 1'b1;
              end
              4'b1101:
              begin
                res = {src[6:0], status_q[`MCD_ST_C]};
                status_d[`MCD_ST_C] = src[7];
                wr_res = 1'b1;
              end
              4'b1100:
              begin
                res = {status_q[`MCD_ST_C], src[7:1]};
                status_d[`MCD_ST_C] = src[0];
                wr_res = 1'b1;
              end
              4'b1110:
              begin
                res = {src[3:0], src[7:4]};
                wr_res = 1'b1;
              end
              4'b0001:
              begin
                status_d[`MCD_ST_Z] = 1'b1;
                if (dst)
                begin
                  fw.wr = 1'b1;
                  t0c_d = ctrl_q[`MCD_CTRL_PSA_T0] && (fa == `MCD_TIMER_ZERO_ADDR);
                end
                else
                  wreg_d = 8'h00;
              end
              4'b0000:
              begin
                if (dst)
                begin
                  fw.data = wreg_q;
                  fw.wr = 1'b1;
                  t0c_d = ctrl_q[`MCD_CTRL_PSA_T0] && (fa == `MCD_TIMER_ZERO_ADDR);
                end
                else if (instr_q == `MCD_MASK_WDT_CLEAR)
                begin
                  wdt_d = 1'b1;
                  status_d[`MCD_ST_TIMEOUT] = 1'b1;
                  status_d[`MCD_ST_POWERDOWN] = 1'b1;
                  events_d[0] = 1'b1;
                end
                else if (instr_q == `MCD_MASK_SLEEP)
                begin
                  stby_d = 1'b1;
                  wdt_d = 1'b1;
                  status_d[`MCD_ST_TIMEOUT] = 1'b1;
                  status_d[`MCD_ST_POWERDOWN] = 1'b0;
                  events_d[1] = 1'b1;
                end
                else if (instr_q == `MCD_MASK_RETURN || instr_q == `MCD_MASK_INT_RETURN)
                begin
                  pop = 1'b1;
                  pc_d = stack_q[sp_q - 3'd1];
                  jmp = 1'b1;
                end
              end
              default: ;
            endcase
          end
          2'b01:
          begin
            res = src;
            case (op[3:2])
              2'b00: res[bn] = 1'b0;
              2'b01: res[bn] = 1'b1;
              2'b10: skip = ~src[bn];
              default: skip = src[bn];
            endcase
            if (!op[3])
            begin
              fw.data = res;
              fw.wr = 1'b1;
              t0c_d = ctrl_q[`MCD_CTRL_PSA_T0] && (fa == `MCD_TIMER_ZERO_ADDR);
            end
          end
          2'b10:
          begin
            if (!instr_q[11])
            begin
              push = 1'b1;
            end
            pc_d = {pchl_q[4:3], instr_q[10:0]};
            jmp = 1'b1;
          end
          default:
          begin
            casez (op)
              4'b00??: wreg_d = lit;
              4'b01??:
              begin
                wreg_d = lit;
                pop = 1'b1;
                pc_d = stack_q[sp_q - 3'd1];
                jmp = 1'b1;
              end
              4'b1000: res = lit | wreg_q;
              4'b1001: res = lit & wreg_q;
              4'b1010: res = lit ^ wreg_q;
              4'b110?:
              begin
                sum = add9(lit, ~wreg_q) + 9'h001;
                res = sum[7:0];
                status_d[`MCD_ST_C] = sum[8];
                status_d[`MCD_ST_DIGIT_CARRY] = ({1'b0, lit[3:0]} + {1'b0, ~wreg_q[3:0]} + 5'h01) > 5'h0f;
              end
              default:
              begin
                sum = add9(lit, wreg_q);
                res = sum[7:0];
                status_d[`MCD_ST_C] = sum[8];
                status_d[`MCD_ST_DIGIT_CARRY] = half_carry(lit, wreg_q);
              end
            endcase
            if (op[3])
            begin
              wreg_d = res;
              status_d[`MCD_ST_Z] = (res == 8'h00);
            end
          end
        endcase
        if (wr_res)
        begin
          if (dst)
          begin
            fw.data = res;
            fw.wr = 1'b1;
            t0c_d = ctrl_q[`MCD_CTRL_PSA_T0] && (fa == `MCD_TIMER_ZERO_ADDR);
          end
          else
            wreg_d = res;
        end
        if (skip)
          pc_d = pc_q + 13'h0002;
        if (push)
          sp_d = sp_q + 3'd1;
        if (pop)
          sp_d = sp_q - 3'd1;
        // A second slot is a forced no-op for taken tests and branches.
        if (skip || jmp)
          state_d = MCD_NOP;
      end
      MCD_NOP: state_d = MCD_IDLE;
      default: state_d = MCD_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    faddr_d = faddr_q;
    pchl_d = pchl_q;
    pins_d = pins_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    // Execution owns the array while busy, so bus accesses wait.
    if ((avs_read || avs_write) && !ack_q && state_q == MCD_IDLE)
    begin
      ack_d = 1'b1;
      if (!avs_write)
      begin
        case (avs_address)
          `MCD_ADDR_CTRL: rdata_d = {30'h0, ctrl_q};
          `MCD_ADDR_INSTR: rdata_d = {18'h0, instr_q};
          `MCD_ADDR_WREG: rdata_d = {24'h0, wreg_q};
          `MCD_ADDR_STATUS: rdata_d = {24'h0, status_q};
          `MCD_ADDR_PC: rdata_d = {19'h0, pc_q};
          `MCD_ADDR_FADDR: rdata_d = {25'h0, faddr_q};
          `MCD_ADDR_FDATA: rdata_d = {24'h0, file_q[faddr_q]};
          `MCD_ADDR_EVENTS: rdata_d = {29'h0, stby_q, events_q};
          `MCD_ADDR_PINS: rdata_d = {24'h0, pins_q};
          `MCD_ADDR_SP: rdata_d = {29'h0, sp_q};
          `MCD_ADDR_STACK_TOP: rdata_d = {19'h0, stack_q[sp_q - 3'd1]};
          `MCD_ADDR_PCHL: rdata_d = {24'h0, pchl_q};
          default: rdata_d = `MCD_BAD_READ;
        endcase
      end
    end
    // A write lands only at the edge where waitrequest is seen low.
    if (bus_wr)
    begin
      case (avs_address)
        `MCD_ADDR_CTRL: ctrl_d[`MCD_CTRL_PSA_T0] = avs_writedata[`MCD_CTRL_PSA_T0];
        `MCD_ADDR_FADDR: faddr_d = avs_writedata[6:0];
        `MCD_ADDR_PCHL: pchl_d = avs_writedata[7:0];
        `MCD_ADDR_PINS: pins_d = avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  assign bus_wr = avs_write && ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign wdt_clear = wdt_q;
  assign t0_prescaler_clear = t0c_q;
  assign standby = stby_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= MCD_IDLE;
      instr_q <= 14'h0000;
      wreg_q <= 8'h00;
      status_q <= `MCD_STATUS_RST;
      pc_q <= 13'h0000;
      pchl_q <= 8'h00;
      pins_q <= 8'h00;
      sp_q <= 3'd0;
      events_q <= 2'h0;
      ctrl_q <= 2'h0;
      faddr_q <= 7'h00;
      wdt_q <= 1'b0;
      t0c_q <= 1'b0;
      stby_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      instr_q <= instr_d;
      wreg_q <= wreg_d;
      status_q <= status_d;
      pc_q <= pc_d;
      pchl_q <= pchl_d;
      pins_q <= pins_d;
      sp_q <= sp_d;
      events_q <= events_d;
      ctrl_q <= ctrl_d;
      faddr_q <= faddr_d;
      wdt_q <= wdt_d;
      t0c_q <= t0c_d;
      stby_q <= stby_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      if (bus_wr && avs_address == `MCD_ADDR_INSTR)
      begin
        instr_q <= avs_writedata[13:0];
        state_q <= MCD_READ;
        stby_q <= 1'b0;
      end
      if (bus_wr && avs_address == `MCD_ADDR_WREG)
        wreg_q <= avs_writedata[7:0];
      if (bus_wr && avs_address == `MCD_ADDR_STATUS)
        status_q <= avs_writedata[7:0];
      if (bus_wr && avs_address == `MCD_ADDR_PC)
        pc_q <= avs_writedata[12:0];
      if (bus_wr && avs_address == `MCD_ADDR_EVENTS)
        events_q <= events_q & ~avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (fw.wr)
      file_q[fw.addr] <= fw.data;
    else if (bus_wr && avs_address == `MCD_ADDR_FDATA)
      file_q[faddr_q] <= avs_writedata[7:0];
    if (push)
      stack_q[sp_q] <= push_val;
  end

endmodule // mcd_core_decode
`default_nettype wire

// ==== mcd_core_decode_sva.sv ====
// Port assertions for the core decode block.
`timescale 1ns/10ps
`default_nettype none
`include "mcd_params.svh"
module mcd_core_decode_sva
  import mcd_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int FILE_WORDS = 128
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Side effects
  input wire logic wdt_clear,
  input wire logic t0_prescaler_clear,
  input wire logic standby
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic req;
  assign req = avs_read || avs_write;
  sequence instr_ack(logic [13:0] v);
    avs_write && !avs_waitrequest && avs_address == `MCD_ADDR_INSTR && avs_writedata[13:0] == v;
  endsequence
  sequence lit_ack;
    avs_write && !avs_waitrequest && avs_address == `MCD_ADDR_INSTR && avs_writedata[13:12] == 2'b11;
  endsequence
  wdt_pulse_a: assert property (wdt_clear |=> !wdt_clear)
    else $error("wdt_clear lasted more than one cycle");
  presc_pulse_a: assert property (t0_prescaler_clear |=> !t0_prescaler_clear)
    else $error("t0_prescaler_clear lasted more than one cycle");
  wdt_cause_a: assert property (instr_ack(`MCD_MASK_WDT_CLEAR) |-> ##[1:6] wdt_clear)
    else $error("watchdog clear gave no wdt_clear pulse");
  sleep_stby_a: assert property (instr_ack(`MCD_MASK_SLEEP) |-> ##[1:6] standby)
    else $error("sleep did not raise standby");
  stby_hold_a: assert property ((standby && !(avs_write && avs_address == `MCD_ADDR_INSTR)) |=> standby)
    else $error("standby dropped without an instruction write");
  lit_presc_a: assert property (lit_ack |-> ##2 !t0_prescaler_clear [*3])
    else $error("literal instruction cleared the timer prescaler");
  nop_quiet_a: assert property (instr_ack(14'h0000) |-> ##2 (!wdt_clear && !standby) [*3])
    else $error("no-operation caused a side effect");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > `MCD_ADDR_PCHL
    |-> avs_readdata == `MCD_BAD_READ)
    else $error("unmapped read returned nonzero data");
  wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("request acknowledged without a wait cycle");
  ack_gap_a: assert property ((req && !avs_waitrequest) |=> (!req || avs_waitrequest))
    else $error("access completed in one cycle");
endmodule // mcd_core_decode_sva
`default_nettype wire

// ==== mcd_params.svh ====
// Constants for the core instruction decode and execute block.
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH
`define MCD_ADDR_CTRL 4'h0
`define MCD_ADDR_INSTR 4'h1
`define MCD_ADDR_WREG 4'h2
`define MCD_ADDR_STATUS 4'h3
`define MCD_ADDR_PC 4'h4
`define MCD_ADDR_FADDR 4'h5
`define MCD_ADDR_FDATA 4'h6
`define MCD_ADDR_EVENTS 4'h7
`define MCD_ADDR_PINS 4'h8
`define MCD_ADDR_SP 4'h9
`define MCD_ADDR_STACK_TOP 4'ha
`define MCD_ADDR_PCHL 4'hb
`define MCD_ST_C 0
`define MCD_ST_DIGIT_CARRY 1
`define MCD_ST_Z 2
`define MCD_ST_POWERDOWN 3
`define MCD_ST_TIMEOUT 4
`define MCD_CTRL_EXEC 0
`define MCD_CTRL_PSA_T0 1
`define MCD_TIMER_ZERO_ADDR 7'h01
`define MCD_PORT_ADDR 7'h06
`define MCD_STATUS_RST 8'h18
`define MCD_MASK_WDT_CLEAR 14'h0064
`define MCD_MASK_SLEEP 14'h0063
`define MCD_MASK_RETURN 14'h0008
`define MCD_MASK_INT_RETURN 14'h0009
`define MCD_BAD_READ 32'h00000000
`endif

// ==== mcd_pkg.sv ====
// Types shared by the core instruction decode block.
package mcd_pkg;
  typedef enum logic [1:0] {MCD_IDLE, MCD_READ, MCD_EXEC, MCD_NOP} mcd_state_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic wr;
  } mcd_file_t;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } mcd_avm_req_t;
endpackage

// ==== mcd_prog_rom.sv ====
// Program memory model holding a short call and return program.
`timescale 1ns/10ps
`default_nettype none
module mcd_prog_rom
(
  // Fetch
  input wire logic [12:0] pc,
  output logic [13:0] word
);
  // Empty words read as no-operation, so a stray fetch is harmless.
  always_comb
  begin
    case (pc)
      13'h0000: word = 14'h2004;
      13'h0001: word = 14'h2806;
      13'h0004: word = 14'h2005;
      13'h0005: word = 14'h3455;
      default: word = 14'h0000;
    endcase
  end
endmodule // mcd_prog_rom
`default_nettype wire

// ==== tb_mcd_core_decode.sv ====
// Self-checking bench for the core decode block.
`timescale 1ns/10ps
`default_nettype none
`include "mcd_params.svh"
module tb_mcd_core_decode
  import mcd_pkg::*;
;
  localparam logic [3:0] w_a = `MCD_ADDR_WREG;
  localparam logic [3:0] st_a = `MCD_ADDR_STATUS;
  localparam logic [3:0] pc_a = `MCD_ADDR_PC;
  localparam logic [3:0] fd_a = `MCD_ADDR_FDATA;
  logic clk;
  logic resetn;
  mcd_avm_req_t req_q;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wdt_clear;
  logic t0_prescaler_clear;
  logic standby;
  logic [13:0] rom_word;
  logic [31:0] rd;
  int failures = 0;
  int check_count = 0;
  int waits;
  int n1;
  int wdt_seen = 0;
  int presc_seen = 0;

  mcd_core_decode mcd_core_decode_inst (.clk(clk), .resetn(resetn), .avs_address(req_q.address),
    .avs_read(req_q.read), .avs_write(req_q.write), .avs_writedata(req_q.writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wdt_clear(wdt_clear),
    .t0_prescaler_clear(t0_prescaler_clear), .standby(standby));
  mcd_prog_rom mcd_prog_rom_inst (.pc(rd[12:0]), .word(rom_word));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (wdt_clear === 1'b1) wdt_seen++;
    if (t0_prescaler_clear === 1'b1) presc_seen++;
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    req_q <= '{address: a, read: !wr, write: wr, writedata: d};
    waits = 0;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      waits++;
      if (waits > 20)
      begin
        failures++;
        $display("Error waitrequest expected low seen high");
        give_verdict();
      end
      @(posedge clk);
    end
    rd = avs_readdata;
    req_q <= '0;
    @(posedge clk);
  endtask

  task automatic chk(input string what, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(what, e, rd & m);
  endtask

  task automatic exec(input logic [13:0] i);
    bus(1'b1, `MCD_ADDR_INSTR, {18'h0, i});
  endtask

  task automatic setf(input logic [6:0] a, input logic [7:0] v);
    bus(1'b1, `MCD_ADDR_FADDR, {25'h0, a});
    bus(1'b1, fd_a, {24'h0, v});
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    resetn = 1'b0;
    req_q = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    chk("status", st_a, 32'h1f, `MCD_STATUS_RST);
    chk("unmapped", 4'hf, 32'hffffffff, `MCD_BAD_READ);
    $display("test reset done");
    bus(1'b1, st_a, 32'h18);
    bus(1'b1, w_a, 32'h0f);
    setf(7'h20, 8'h01);
    exec(14'h07a0);
    chk("file", fd_a, 32'hff, 32'h10);
    chk("w", w_a, 32'hff, 32'h0f);
    chk("status", st_a, 32'h7, 32'h2);
    exec(14'h0520);
    chk("w", w_a, 32'hff, 32'h00);
    chk("status", st_a, 32'h7, 32'h6);
    bus(1'b1, w_a, 32'h03);
    exec(14'h04a0);
    chk("file", fd_a, 32'hff, 32'h13);
    chk("status", st_a, 32'h7, 32'h2);
    $display("test byte done");
    bus(1'b1, pc_a, 32'h100);
    setf(7'h21, 8'h02);
    exec(14'h0000);
    chk("pc", pc_a, 32'h1fff, 32'h101);
    n1 = waits;
    exec(14'h0ba1);
    chk("pc", pc_a, 32'h1fff, 32'h102);
    exec(14'h0ba1);
    chk("pc", pc_a, 32'h1fff, 32'h104);
    cmp("cycles", 32'(n1 + 1), 32'(waits));
    chk("file", fd_a, 32'hff, 32'h00);
    chk("status", st_a, 32'h7, 32'h2);
    setf(7'h22, 8'hff);
    exec(14'h0fa2);
    chk("pc", pc_a, 32'h1fff, 32'h106);
    $display("test skip done");
    setf(7'h23, 8'h00);
    exec(14'h17a3);
    chk("file", fd_a, 32'hff, 32'h80);
    exec(14'h1fa3);
    exec(14'h1ba3);
    exec(14'h13a3);
    chk("file", fd_a, 32'hff, 32'h00);
    chk("pc", pc_a, 32'h1fff, 32'h10b);
    $display("test bit done");
    bus(1'b1, `MCD_ADDR_PCHL, 32'h0);
    bus(1'b1, pc_a, 32'h0);
    repeat (5)
    begin
      bus(1'b0, pc_a, 32'h0);
      exec(rom_word);
    end
    chk("pc", pc_a, 32'h1fff, 32'h006);
    chk("w", w_a, 32'hff, 32'h55);
    bus(1'b1, `MCD_ADDR_PCHL, 32'h18);
    bus(1'b1, pc_a, 32'h300);
    exec(14'h2123);
    chk("pc", pc_a, 32'h1fff, 32'h1923);
    chk("stack top", `MCD_ADDR_STACK_TOP, 32'h1fff, 32'h301);
    chk("stack depth", `MCD_ADDR_SP, 32'h7, 32'h1);
    exec(`MCD_MASK_RETURN);
    chk("pc", pc_a, 32'h1fff, 32'h301);
    bus(1'b1, `MCD_ADDR_PCHL, 32'h08);
    exec(14'h2d55);
    chk("pc", pc_a, 32'h1fff, 32'h0d55);
    exec(14'h2000);
    exec(`MCD_MASK_INT_RETURN);
    chk("pc", pc_a, 32'h1fff, 32'h0d56);
    $display("test flow done");
    n1 = wdt_seen;
    bus(1'b1, st_a, 32'h0);
    exec(`MCD_MASK_WDT_CLEAR);
    chk("status", st_a, 32'h18, 32'h18);
    cmp("wdt pulses", 32'h1, 32'(wdt_seen - n1));
    bus(1'b1, st_a, 32'h0);
    exec(`MCD_MASK_SLEEP);
    chk("status", st_a, 32'h18, 32'h10);
    chk("events", `MCD_ADDR_EVENTS, 32'h7, 32'h7);
    cmp("standby", 32'h1, {31'h0, standby});
    bus(1'b1, `MCD_ADDR_EVENTS, 32'h3);
    exec(14'h0000);
    cmp("standby", 32'h0, {31'h0, standby});
    chk("events", `MCD_ADDR_EVENTS, 32'h7, 32'h0);
    $display("test power done");
    bus(1'b1, st_a, 32'h18);
    setf(7'h24, 8'h5a);
    exec(14'h09a4);
    chk("file", fd_a, 32'hff, 32'ha5);
    exec(14'h0924);
    chk("w", w_a, 32'hff, 32'h5a);
    chk("status", st_a, 32'h7, 32'h0);
    exec(14'h01a4);
    chk("file", fd_a, 32'hff, 32'h00);
    chk("status", st_a, 32'h7, 32'h4);
    bus(1'b1, st_a, 32'h18);
    exec(14'h0100);
    chk("w", w_a, 32'hff, 32'h00);
    chk("status", st_a, 32'h7, 32'h4);
    $display("test clear done");
    bus(1'b1, st_a, 32'h18);
    exec(14'h3380);
    exec(14'h3801);
    exec(14'h3980);
    chk("w", w_a, 32'hff, 32'h80);
    exec(14'h3a80);
    chk("status", st_a, 32'h7, 32'h4);
    exec(14'h3e0f);
    exec(14'h3ff1);
    chk("status", st_a, 32'h7, 32'h7);
    exec(14'h3c05);
    chk("status", st_a, 32'h7, 32'h3);
    exec(14'h3d03);
    chk("w", w_a, 32'hff, 32'hfe);
    chk("status", st_a, 32'h7, 32'h0);
    $display("test literal done");
    bus(1'b1, st_a, 32'h1c);
    setf(7'h25, 8'h81);
    exec(14'h0da5);
    chk("file", fd_a, 32'hff, 32'h02);
    chk("status", st_a, 32'h7, 32'h5);
    exec(14'h0ca5);
    chk("status", st_a, 32'h7, 32'h4);
    exec(14'h0ea5);
    chk("file", fd_a, 32'hff, 32'h18);
    bus(1'b1, w_a, 32'h77);
    exec(14'h00a5);
    exec(14'h0060);
    chk("file", fd_a, 32'hff, 32'h77);
    chk("status", st_a, 32'h7, 32'h4);
    $display("test rotate done");
    bus(1'b1, `MCD_ADDR_PINS, 32'ha5);
    setf(7'h06, 8'h3c);
    exec(14'h0906);
    chk("w", w_a, 32'hff, 32'h5a);
    n1 = presc_seen;
    bus(1'b1, `MCD_ADDR_CTRL, 32'h2);
    exec(14'h0181);
    bus(1'b1, `MCD_ADDR_CTRL, 32'h0);
    exec(14'h0181);
    chk("status", st_a, 32'h7, 32'h4);
    cmp("prescaler pulses", 32'h1, 32'(presc_seen - n1));
    $display("test timer done");
    give_verdict();
  end
endmodule // tb_mcd_core_decode

bind mcd_core_decode mcd_core_decode_sva #(.STACK_DEPTH(STACK_DEPTH), .FILE_WORDS(FILE_WORDS)) mcd_sva_inst (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wdt_clear(wdt_clear), .t0_prescaler_clear(t0_prescaler_clear), .standby(standby));
`default_nettype wire
